//--- csd_pkg.sv
// Shared constants and types of the association control word decoder
package csd_pkg;

    ////////////////////////////////////////////////////////////////////
    // Register byte offsets on the Avalon-MM slave
    localparam logic [7:0] OFF_CTRL_WORD = 8'h00;
    localparam logic [7:0] OFF_COMMAND = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_CSR = 8'h0C;
    localparam logic [7:0] OFF_FETCH_MASK = 8'h10;

    // Reset values
    localparam logic [31:0] CTRL_WORD_RESET = 32'h0000_0000;
    localparam logic [31:0] CSR_RESET = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////
    // Control word field positions
    localparam int BIT_VERIFY = 29;
    localparam int BIT_AUTH_ONLY = 27;
    localparam int BIT_OR_MERGE = 26;
    localparam int BIT_TRUNC_MAC = 25;
    localparam int BIT_SAVE_HASH = 24;
    localparam int BIT_LOAD_KEYS = 23;
    localparam int BIT_LOAD_IV = 22;
    localparam int BIT_FIRST_BLOCK = 21;
    localparam int BIT_OUTBOUND = 20;
    localparam int ALGORITHM_SELECT_LSB = 10;
    localparam int ALGORITHM_SELECT_W = 7;
    localparam int BIT_ENCRYPT = 9;
    localparam int KEY_SIZE_LSB = 7;
    localparam int KEY_SIZE_W = 2;
    localparam int TASK_LSB = 4;
    localparam int TASK_W = 3;
    localparam int CIPHER_LSB = 0;
    localparam int CIPHER_W = 4;
    // Reserved positions 31:30, 28 and 19:17
    localparam logic [31:0] RESERVED_MASK = 32'hD00E_0000;

    // Command and status fields
    localparam int CMD_START_BIT = 0;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_RESULT_LSB = 4;
    localparam int ST_COUNT_LSB = 8;

    ////////////////////////////////////////////////////////////////////
    // Association layout in memory, one bit per word
    localparam int SA_WORDS = 18;
    localparam int IDX_W = 5;
    localparam logic [4:0] LAST_IDX = 5'h11;
    localparam logic [17:0] MASK_CTRL = 18'h00001;
    localparam logic [17:0] MASK_KEYS = 18'h001FE;
    localparam logic [17:0] MASK_IV = 18'h01E00;
    localparam logic [17:0] MASK_HASH = 18'h3E000;
    localparam logic [2:0] HMAC_FULL_WORDS = 3'h5;
    localparam logic [2:0] HMAC_TRUNC_WORDS = 3'h3;

    // Decoded control word
    typedef struct packed {
        logic verify_en;
        logic auth_only;
        logic or_merge;
        logic truncated_mac_result;
        logic save_intermediate_hash;
        logic load_fresh_keys;
        logic load_init_vector;
        logic first_block_mark;
        logic outbound;
        logic [6:0] algorithm_select;
        logic encrypt_select;
        logic [1:0] key_size;
        logic [2:0] parallel_task_select;
        logic [3:0] cipher_mode_select;
    } csd_cfg_t;

    // Fetch walker states
    typedef enum logic [1:0] {
        PL_IDLE = 2'b00,
        PL_WALK = 2'b01,
        PL_DONE = 2'b10
    } csd_plan_state_t;

endpackage

//--- csd_cfg_if.sv
// Link between the bus front end, the word decoder and the fetch walker
`timescale 1ns/1ps
`default_nettype none
interface csd_cfg_if;
    import csd_pkg::*;
    logic load;
    logic [31:0] word;
    csd_cfg_t cfg;
    logic start;
    logic busy;
    logic done;
    logic fetch_valid;
    logic fetch_ready;
    logic [4:0] fetch_index;
    logic [4:0] fetch_count;
    logic [17:0] fetch_mask;
    modport dec (input load, word, output cfg);
    modport plan (input cfg, start, fetch_ready,
        output busy, done, fetch_valid, fetch_index, fetch_count, fetch_mask);
endinterface
`default_nettype wire

//--- csd_word_decode.sv
// Captures the control word and splits it into its fields
`timescale 1ns/1ps
`default_nettype none
module csd_word_decode (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link
    csd_cfg_if.dec link
);
    import csd_pkg::*;

    csd_cfg_t s_reg;
    csd_cfg_t s_next;

    // Field split; reserved positions are never looked at
    function automatic csd_cfg_t split(input logic [31:0] w);
        csd_cfg_t c;
        c.verify_en = w[BIT_VERIFY];
        c.auth_only = w[BIT_AUTH_ONLY];
        c.or_merge = w[BIT_OR_MERGE];
        c.truncated_mac_result = w[BIT_TRUNC_MAC];
        c.save_intermediate_hash = w[BIT_SAVE_HASH];
        c.load_fresh_keys = w[BIT_LOAD_KEYS];
        c.load_init_vector = w[BIT_LOAD_IV];
        c.first_block_mark = w[BIT_FIRST_BLOCK];
        c.outbound = w[BIT_OUTBOUND];
        c.algorithm_select = w[ALGORITHM_SELECT_LSB +: ALGORITHM_SELECT_W];
        c.encrypt_select = w[BIT_ENCRYPT];
        c.key_size = w[KEY_SIZE_LSB +: KEY_SIZE_W];
        c.parallel_task_select = w[TASK_LSB +: TASK_W];
        c.cipher_mode_select = w[CIPHER_LSB +: CIPHER_W];
        return c;
    endfunction

    // Load a new word or hold
    always_comb begin
        s_next = s_reg;
        if (link.load) begin
            s_next = split(link.word);
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign link.cfg = s_reg;
endmodule
`default_nettype wire

//--- csd_fetch_plan.sv
// Walks the association words that the current operation needs
`timescale 1ns/1ps
`default_nettype none
module csd_fetch_plan (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link
    csd_cfg_if.plan link
);
    import csd_pkg::*;

    typedef struct packed {
        csd_plan_state_t st;
        logic [4:0] idx;
        logic [17:0] mask;
        logic [4:0] count;
    } csd_plan_t;

    csd_plan_t s_reg;
    csd_plan_t s_next;

    // Smallest set of words for this operation
    function automatic logic [17:0] plan_words(input csd_cfg_t c);
        logic [17:0] m;
        m = MASK_CTRL;
        if (c.load_fresh_keys) begin
            m = m | MASK_KEYS;
        end
        if (c.load_init_vector) begin
            m = m | MASK_IV;
        end
        if (c.save_intermediate_hash && !c.first_block_mark) begin
            m = m | MASK_HASH;
        end
        return m;
    endfunction

    // Walker: skips unneeded words, waits on ready for needed ones
    always_comb begin
        s_next = s_reg;
        unique case (s_reg.st)
            PL_IDLE: begin
                if (link.start) begin
                    s_next.st = PL_WALK;
                    s_next.mask = plan_words(link.cfg);
                    s_next.idx = '0;
                    s_next.count = '0;
                end
            end
            PL_WALK: begin
                if (!s_reg.mask[s_reg.idx] || link.fetch_ready) begin
                    if (s_reg.mask[s_reg.idx]) begin
                        s_next.count = s_reg.count + 5'h01;
                    end
                    if (s_reg.idx == LAST_IDX) begin
                        s_next.st = PL_DONE;
                    end else begin
                        s_next.idx = s_reg.idx + 5'h01;
                    end
                end
            end
            PL_DONE: begin
                s_next.st = PL_IDLE;
            end
            default: begin
                s_next.st = PL_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '{st: PL_IDLE, idx: '0, mask: '0, count: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign link.busy = (s_reg.st != PL_IDLE);
    assign link.done = (s_reg.st == PL_DONE);
    assign link.fetch_valid = (s_reg.st == PL_WALK) && s_reg.mask[s_reg.idx];
    assign link.fetch_index = s_reg.idx;
    assign link.fetch_count = s_reg.count;
    assign link.fetch_mask = s_reg.mask;
endmodule
`default_nettype wire

//--- csd_assoc_decode.sv
// Association control word decoder with Avalon-MM register access
//
// Functional notes
// - Fetch only the association words this operation needs
// - Bit 29 enables standardized verification procedures
// - Bit 27 selects check-value-only, no receive output
// - Bit 26 ORs word into status register
// - Bit 25 truncates SHA-1 HMAC result to three
// - Bit 24 saves intermediate hash for continuation
// - Bit 23 loads fresh keys, else keeps
// - Bit 22 loads IV, else chained IV
// - Bit 21 marks first block, IV fed
// - Bit 20 selects outgoing, else incoming flow
//
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module csd_assoc_decode #(
    parameter logic [6:0] SHA1_HMAC_ALGORITHM_SELECT = 7'h01
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // Avalon-MM slave
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Association word fetch
    output logic SA_FETCH_VALID,
    output logic [csd_pkg::IDX_W-1:0] SA_FETCH_INDEX,
    input wire logic SA_FETCH_READY,
    output logic SA_FETCH_DONE,
    // Decoded settings to the engine
    output logic CFG_VERIFY_EN,
    output logic CFG_AUTH_ONLY,
    output logic CFG_RX_OUT_EN,
    output logic CFG_SAVE_HASH,
    output logic CFG_IV_FROM_SA,
    output logic CFG_IV_CHAINED,
    output logic CFG_FIRST_BLOCK,
    output logic CFG_OUTBOUND,
    output logic [2:0] CFG_RESULT_WORDS,
    output logic [csd_pkg::ALGORITHM_SELECT_W-1:0] CFG_ALGORITHM_SELECT,
    output logic CFG_ENCRYPT,
    output logic [csd_pkg::KEY_SIZE_W-1:0] CFG_KEY_SIZE,
    output logic [csd_pkg::TASK_W-1:0] CFG_TASK,
    output logic [csd_pkg::CIPHER_W-1:0] CFG_CIPHER,
    // Key load strobe and internal control-status value
    output logic LOAD_KEYS_PULSE,
    output logic [31:0] CSR_VALUE
);
    import csd_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] csr;
        logic start;
        logic load_keys;
        logic rd_valid;
        logic [31:0] rdata;
    } csd_top_t;

    csd_top_t s_reg;
    csd_top_t s_next;
    csd_cfg_if link ();
    logic [31:0] wmerge;
    logic [31:0] clean_ctrl;
    logic engaged;
    logic apply;
    logic sel_aligned;
    logic [2:0] result_words;
    logic [31:0] status_word;

    ////////////////////////////////////////////////////////////////////
    // Submodules

    // Field capture
    csd_word_decode u_decode (
        .clk(CLK),
        .rst_n(RSTN),
        .link(link)
    );

    // Word walker
    csd_fetch_plan u_plan (
        .clk(CLK),
        .rst_n(RSTN),
        .link(link)
    );

    ////////////////////////////////////////////////////////////////////
    // Bus decode

    // Byte lane merge of write data into the control word
    genvar b;
    generate
        for (b = 0; b < 4; b = b + 1) begin : g_lane
            assign wmerge[8*b +: 8] = AVS_BYTEENABLE[b] ?
                AVS_WRITEDATA[8*b +: 8] : s_reg.ctrl[8*b +: 8];
        end
    endgenerate

    // Access qualifiers
    assign sel_aligned = (AVS_ADDRESS[1:0] == 2'h0);
    assign engaged = s_reg.start || link.busy;
    assign apply = AVS_WRITE && (AVS_ADDRESS == OFF_COMMAND)
        && AVS_BYTEENABLE[0] && AVS_WRITEDATA[CMD_START_BIT] && !engaged;
    assign clean_ctrl = s_reg.ctrl & ~RESERVED_MASK;

    // Writes never wait; reads wait one cycle for registered data
    assign AVS_WAITREQUEST = AVS_READ && !s_reg.rd_valid;
    assign AVS_READDATA = s_reg.rdata;

    ////////////////////////////////////////////////////////////////////
    // Result width and status word

    // Truncation only touches the SHA-1 HMAC selection
    always_comb begin
        result_words = HMAC_FULL_WORDS;
        if (link.cfg.truncated_mac_result
            && link.cfg.algorithm_select == SHA1_HMAC_ALGORITHM_SELECT) begin
            result_words = HMAC_TRUNC_WORDS;
        end
    end

    // Status word layout
    always_comb begin
        status_word = '0;
        status_word[ST_BUSY_BIT] = engaged;
        status_word[ST_RESULT_LSB +: 3] = result_words;
        status_word[ST_COUNT_LSB +: IDX_W] = link.fetch_count;
    end

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_next = s_reg;
        s_next.start = 1'h0;
        s_next.load_keys = 1'h0;
        s_next.rd_valid = 1'h0;
        // Control word is writable at any time
        if (AVS_WRITE && (AVS_ADDRESS == OFF_CTRL_WORD)) begin
            s_next.ctrl = wmerge;
        end
        // Start: capture fields, merge or replace the status register
        if (apply) begin
            s_next.start = 1'h1;
            s_next.load_keys = s_reg.ctrl[BIT_LOAD_KEYS];
            if (s_reg.ctrl[BIT_OR_MERGE]) begin
                s_next.csr = s_reg.csr | clean_ctrl;
            end else begin
                s_next.csr = clean_ctrl;
            end
        end
        // Read data registered for the answer cycle
        if (AVS_READ && !s_reg.rd_valid) begin
            s_next.rd_valid = 1'h1;
            s_next.rdata = '0;
            if (sel_aligned) begin
                unique case (AVS_ADDRESS)
                    OFF_CTRL_WORD: s_next.rdata = s_reg.ctrl;
                    OFF_STATUS: s_next.rdata = status_word;
                    OFF_CSR: s_next.rdata = s_reg.csr;
                    OFF_FETCH_MASK: s_next.rdata = {14'h0000, link.fetch_mask};
                    default: s_next.rdata = '0;
                endcase
            end
        end
    end

    // State register
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            s_reg <= '{ctrl: CTRL_WORD_RESET, csr: CSR_RESET, start: 1'h0,
                load_keys: 1'h0, rd_valid: 1'h0, rdata: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Link and outputs

    // Fields captured on start, walk begins the cycle after
    assign link.load = apply;
    assign link.word = s_reg.ctrl;
    assign link.start = s_reg.start;
    assign link.fetch_ready = SA_FETCH_READY;

    assign SA_FETCH_VALID = link.fetch_valid;
    assign SA_FETCH_INDEX = link.fetch_index;
    assign SA_FETCH_DONE = link.done;

    // Decoded flags
    assign CFG_VERIFY_EN = link.cfg.verify_en;
    assign CFG_AUTH_ONLY = link.cfg.auth_only;
    assign CFG_RX_OUT_EN = !link.cfg.auth_only;
    assign CFG_SAVE_HASH = link.cfg.save_intermediate_hash;
    assign CFG_IV_FROM_SA = link.cfg.load_init_vector;
    assign CFG_IV_CHAINED = !link.cfg.load_init_vector;
    assign CFG_FIRST_BLOCK = link.cfg.first_block_mark;
    assign CFG_OUTBOUND = link.cfg.outbound;
    assign CFG_RESULT_WORDS = result_words;

    // Decoded fields
    assign CFG_ALGORITHM_SELECT = link.cfg.algorithm_select;
    assign CFG_ENCRYPT = link.cfg.encrypt_select;
    assign CFG_KEY_SIZE = link.cfg.key_size;
    assign CFG_TASK = link.cfg.parallel_task_select;
    assign CFG_CIPHER = link.cfg.cipher_mode_select;

    assign LOAD_KEYS_PULSE = s_reg.load_keys;
    assign CSR_VALUE = s_reg.csr;

    ////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);

    // Start with continuation and hash save requested
    sequence s_apply_cont;
        apply && s_reg.ctrl[BIT_SAVE_HASH] && !s_reg.ctrl[BIT_FIRST_BLOCK];
    endsequence

    // Start followed by the walker taking up
    sequence s_walk_begins;
        link.start ##1 link.busy;
    endsequence

    property p_fetch_planned;
        SA_FETCH_VALID |-> link.fetch_mask[SA_FETCH_INDEX]
            && (link.fetch_mask[12:9] == {4{CFG_IV_FROM_SA}});
    endproperty
    a_fetch_planned: assert property (p_fetch_planned)
        else $error("fetch of a word outside the plan");

    property p_fetch_count;
        SA_FETCH_DONE |->
            (link.fetch_count == IDX_W'($countones(link.fetch_mask)));
    endproperty
    a_fetch_count: assert property (p_fetch_count)
        else $error("fetched word count differs from plan");

    property p_verify;
        apply |=> (CFG_VERIFY_EN == $past(s_reg.ctrl[BIT_VERIFY]));
    endproperty
    a_verify: assert property (p_verify)
        else $error("verification setting not taken from bit 29");

    property p_auth_only;
        apply && s_reg.ctrl[BIT_AUTH_ONLY] |=>
            CFG_AUTH_ONLY && !CFG_RX_OUT_EN;
    endproperty
    a_auth_only: assert property (p_auth_only)
        else $error("check-value-only setting not applied");

    property p_or_merge;
        apply |=> (CSR_VALUE == ($past(s_reg.ctrl[BIT_OR_MERGE]) ?
            ($past(CSR_VALUE) | $past(clean_ctrl)) : $past(clean_ctrl)));
    endproperty
    a_or_merge: assert property (p_or_merge)
        else $error("status register merge wrong");

    property p_truncate;
        apply && s_reg.ctrl[BIT_TRUNC_MAC]
            && (s_reg.ctrl[ALGORITHM_SELECT_LSB +: ALGORITHM_SELECT_W] == SHA1_HMAC_ALGORITHM_SELECT)
            |=> (CFG_RESULT_WORDS == 3'h3);
    endproperty
    a_truncate: assert property (p_truncate)
        else $error("truncated HMAC result not three words");

    property p_full_result;
        apply && !s_reg.ctrl[BIT_TRUNC_MAC] |=> (CFG_RESULT_WORDS == 3'h5);
    endproperty
    a_full_result: assert property (p_full_result)
        else $error("full result width wrong");

    property p_hash_words;
        s_apply_cont |-> ##1 s_walk_begins
            ##0 (link.fetch_mask[17:13] == 5'h1F);
    endproperty
    a_hash_words: assert property (p_hash_words)
        else $error("saved hash words not planned for continuation");

    property p_keys;
        apply |=> (LOAD_KEYS_PULSE == $past(s_reg.ctrl[BIT_LOAD_KEYS]))
            ##1 !LOAD_KEYS_PULSE
            ##0 (link.fetch_mask[8:1]
                == {8{$past(s_reg.ctrl[BIT_LOAD_KEYS], 2)}});
    endproperty
    a_keys: assert property (p_keys)
        else $error("key load not following bit 23");

    property p_iv;
        apply |=> (CFG_IV_FROM_SA == $past(s_reg.ctrl[BIT_LOAD_IV]))
            && (CFG_IV_CHAINED != CFG_IV_FROM_SA);
    endproperty
    a_iv: assert property (p_iv)
        else $error("IV source not following bit 22");

    property p_first_block;
        apply |=> (CFG_FIRST_BLOCK == $past(s_reg.ctrl[BIT_FIRST_BLOCK]))
            [*2];
    endproperty
    a_first_block: assert property (p_first_block)
        else $error("first block mark not following bit 21");

    property p_direction;
        apply |=> (CFG_OUTBOUND == $past(s_reg.ctrl[BIT_OUTBOUND]));
    endproperty
    a_direction: assert property (p_direction)
        else $error("flow direction not following bit 20");

    property p_fields;
        apply |=> (CFG_ALGORITHM_SELECT == $past(s_reg.ctrl[16:10]))
            && (CFG_ENCRYPT == $past(s_reg.ctrl[9]))
            && (CFG_KEY_SIZE == $past(s_reg.ctrl[8:7]))
            && (CFG_TASK == $past(s_reg.ctrl[6:4]))
            && (CFG_CIPHER == $past(s_reg.ctrl[3:0]));
    endproperty
    a_fields: assert property (p_fields)
        else $error("field decode wrong");

    property p_read_answer;
        AVS_READ && AVS_WAITREQUEST |=> !AVS_WAITREQUEST || !AVS_READ;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read not answered in one wait cycle");

endmodule
`default_nettype wire

//--- csd_sa_mem_model.sv
// Far-side model: association memory answering word fetches
`timescale 1ns/1ps
`default_nettype none
module csd_sa_mem_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fetch link
    input wire logic valid,
    input wire logic [4:0] index,
    output logic ready,
    // Bench control and results
    input wire logic slow,
    input wire logic clr,
    output int count,
    output logic order_ok
);
    logic [4:0] last;
    logic [1:0] ph;
    // Slow mode accepts on every third cycle only
    assign ready = valid && (!slow || ph == 2'h2);
    // Counts accepted words and watches their order
    always_ff @(posedge clk) begin
        if (!rst_n || clr) begin
            ph <= 2'h0;
            count <= 0;
            order_ok <= 1'b1;
            last <= 5'h00;
        end else begin
            ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
            if (valid && ready) begin
                count <= count + 1;
                if (count != 0 && index <= last) order_ok <= 1'b0;
                last <= index;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench of the association control word decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import csd_pkg::*;
    localparam logic [6:0] SHA1 = 7'h01;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [3:0] be = 4'hF;
    logic slow = 1'b0;
    logic clr = 1'b0;
    logic [31:0] rdv;
    logic [31:0] csr_exp;
    wire [31:0] rdat;
    wire [31:0] csr_v;
    wire [24:0] cfg_v;
    wire [4:0] f_idx;
    wire [2:0] res_w;
    wire wait_req;
    wire f_valid;
    wire f_ready;
    wire f_done;
    wire keys;
    logic ord_ok;
    int f_cnt;
    int key_cnt;
    int n_fail = 0;
    int check_count = 0;
    logic [31:0] tbl [6] = '{32'h0000_0000, 32'h2BF0_0400,
        32'h0380_0800, 32'hD40E_03FF, 32'h0250_5A5A, 32'h01C0_0000};

    ////////////////////////////////////////////////////////////////////
    // 200 MHz clock
    always #2.5 clk = ~clk;

    // Counts key load strobes of one operation
    always @(posedge clk) begin
        if (clr) key_cnt <= 0;
        else if (keys === 1'b1) key_cnt <= key_cnt + 1;
    end

    // Design and far-side model
    csd_assoc_decode #(.SHA1_HMAC_ALGORITHM_SELECT(SHA1)) dut (
        .CLK(clk), .RSTN(rstn), .AVS_ADDRESS(addr), .AVS_READ(rd_en),
        .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be),
        .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_req),
        .SA_FETCH_VALID(f_valid), .SA_FETCH_INDEX(f_idx),
        .SA_FETCH_READY(f_ready), .SA_FETCH_DONE(f_done),
        .CFG_VERIFY_EN(cfg_v[24]), .CFG_AUTH_ONLY(cfg_v[23]),
        .CFG_RX_OUT_EN(cfg_v[22]), .CFG_SAVE_HASH(cfg_v[21]),
        .CFG_IV_FROM_SA(cfg_v[20]), .CFG_IV_CHAINED(cfg_v[19]),
        .CFG_FIRST_BLOCK(cfg_v[18]), .CFG_OUTBOUND(cfg_v[17]),
        .CFG_RESULT_WORDS(res_w), .CFG_ALGORITHM_SELECT(cfg_v[16:10]),
        .CFG_ENCRYPT(cfg_v[9]), .CFG_KEY_SIZE(cfg_v[8:7]),
        .CFG_TASK(cfg_v[6:4]), .CFG_CIPHER(cfg_v[3:0]),
        .LOAD_KEYS_PULSE(keys), .CSR_VALUE(csr_v));
    csd_sa_mem_model mem (
        .clk(clk), .rst_n(rstn), .valid(f_valid), .index(f_idx),
        .ready(f_ready), .slow(slow), .clr(clr), .count(f_cnt),
        .order_ok(ord_ok));

    ////////////////////////////////////////////////////////////////////
    // Prints counts and verdict, then stops
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Compares one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One Avalon-MM transfer, held until waitrequest is low
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr_en <= w;
        rd_en <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        rdv = rdat;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        if (n >= 50) begin
            n_fail++;
            finish_test();
        end
    endtask

    // Loads a word, starts, optionally pokes while busy, checks
    task automatic run(input logic [31:0] w, input logic hit);
        int n;
        int cnt;
        logic [31:0] m;
        logic [17:0] mk;
        logic [2:0] rw;
        m = w & ~RESERVED_MASK;
        csr_exp = w[BIT_OR_MERGE] ? (csr_exp | m) : m;
        mk = MASK_CTRL | (w[23] ? MASK_KEYS : 18'h0)
            | (w[22] ? MASK_IV : 18'h0)
            | ((w[24] && !w[21]) ? MASK_HASH : 18'h0);
        rw = (w[25] && w[16:10] == SHA1) ? 3'h3 : 3'h5;
        cnt = 1 + 8 * w[23] + 4 * w[22] + 5 * (w[24] && !w[21]);
        bus(1'b1, OFF_CTRL_WORD, w);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        bus(1'b1, OFF_COMMAND, 32'h1);
        if (hit) begin
            bus(1'b1, OFF_CTRL_WORD, ~w);
            bus(1'b1, OFF_COMMAND, 32'h1);
            bus(1'b0, OFF_STATUS, 32'h0);
            chk(rdv[ST_BUSY_BIT], 1'b1);
        end
        n = 0;
        while (f_done !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (n >= 400) begin
            n_fail++;
            finish_test();
        end
        @(posedge clk);
        chk(cfg_v, {w[29], w[27], !w[27], w[24], w[22], !w[22], w[21],
            w[20], w[16:0]});
        chk(res_w, rw);
        chk(f_cnt, cnt);
        chk(ord_ok, 1'b1);
        chk(key_cnt, w[23]);
        chk(csr_v, csr_exp);
        bus(1'b0, OFF_CSR, 32'h0);
        chk(rdv, csr_exp);
        bus(1'b0, OFF_STATUS, 32'h0);
        chk(rdv, {19'h0, 5'(cnt), 1'b0, rw, 4'h0});
        bus(1'b0, OFF_FETCH_MASK, 32'h0);
        chk(rdv, {14'h0, mk});
    endtask

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        csr_exp = 32'h0000_0000;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        bus(1'b0, OFF_CTRL_WORD, 32'h0);
        chk(rdv, CTRL_WORD_RESET);
        bus(1'b0, OFF_CSR, 32'h0);
        chk(rdv, CSR_RESET);
        chk({cfg_v[22], cfg_v[19], res_w}, 5'h1D);
        bus(1'b1, 8'h44, 32'hFFFF_FFFF);
        bus(1'b0, 8'h40, 32'h0);
        chk(rdv, 32'h0000_0000);
        be <= 4'h3;
        bus(1'b1, OFF_CTRL_WORD, 32'hFFFF_FFFF);
        be <= 4'hF;
        bus(1'b0, OFF_CTRL_WORD, 32'h0);
        chk(rdv, 32'h0000_FFFF);
        $display("test 1 done");
        for (int i = 0; i < 6; i++) begin
            slow <= i[0];
            run(tbl[i], i == 5);
            $display("test %0d done", i + 2);
        end
        finish_test();
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        finish_test();
    end
endmodule
`default_nettype wire
